/* src/flash_guard.sv */
// Summary of operation
// - protected region from page boundary to top
// - protect copy loaded from nonvolatile byte
// - debug writes change protect copy; armed defeat only sets disable bit
// - boundary bits plus ones give limit
// - protection on when disable bit zero
// - 55 then AA allows disable bit
// - redirection needs no-redirect bit zero
// - redirect only on partial protection
// - vectors redirected, reset vector never
// - untrusted access to flash and RAM blocked while secure, reads zero
// - secure code keeps full access
// - option copy loaded at reset
// - only 1:0 leaves device unsecured
// - debug module disallowed while secure
// - key unlock needs key enable bit
// - key access turns writes into compares
// - full key match unsecures until reset
// - key writes only from secure code
// - blank check success unsecures
`timescale 1ns/1ps
`default_nettype none
module flash_guard
    import flash_guard_pkg::*;
#(
    parameter logic [15:0] FLASH_BASE = 16'hC000,
    parameter logic [15:0] RAM_BASE   = 16'h00B0,
    parameter logic [15:0] RAM_TOP    = 16'h02AF,
    parameter logic [15:0] KEY_BASE   = 16'hFFB0
)(
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic        I_WB_DEBUG,
    output logic [31:0]      O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic [7:0]  I_NV_PROT,
    input  wire logic [7:0]  I_NV_OPT,
    input  wire logic [63:0] I_NV_KEY,
    input  wire logic        I_BLANK_OK,
    input  wire logic        I_MEM_REQ,
    input  wire logic        I_MEM_WE,
    input  wire logic        I_MEM_FETCH,
    input  wire logic [15:0] I_MEM_ADDR,
    input  wire logic [7:0]  I_MEM_WDATA,
    input  wire logic        I_MEM_SECURE_SRC,
    input  wire logic        I_MEM_DEBUG,
    input  wire logic [7:0]  I_ARRAY_RDATA,
    output logic             O_ARRAY_REQ,
    output logic             O_ARRAY_WE,
    output logic [15:0]      O_ARRAY_ADDR,
    output logic [7:0]       O_ARRAY_WDATA,
    output logic [7:0]       O_MEM_RDATA,
    output logic             O_MEM_VALID,
    output logic             O_DEBUG_EN_OK
);
    logic [7:0]     prot;
    logic [7:0]     opt;
    logic [7:0]     cfg;
    logic           loaded;
    logic           key_access_bit_q;
    logic           pend_rd;
    logic           pend_zero;
    defeat_state_t  defeat;
    defeat_state_t  next_defeat;

    wire logic        wb_req;
    wire logic        wb_wr;
    wire logic        wr_prot;
    wire logic        wr_defeat;
    wire logic        wr_cfg;
    wire logic        armed;
    wire logic [7:0]  wb_byte;
    wire logic [31:0] rd_word;
    wire logic [31:0] status;
    wire logic        secure;
    wire logic        key_access_bit;
    wire logic [15:0] last_unprot;
    wire logic        prot_active;
    wire logic        redirect;
    wire logic        in_protected;
    wire logic [15:0] mem_addr_out;
    wire logic        tgt_secure;
    wire logic        trusted;
    wire logic        blocked;
    wire logic        key_hit;
    wire logic        key_wr;
    wire logic        key_match;
    wire logic        unlock;
    wire logic        arr_we;
    wire logic        arr_req;

    // bus decode
    assign wb_req    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wb_wr     = wb_req && I_WB_WE && I_WB_SEL[0];
    assign wb_byte   = I_WB_DAT[7:0];
    assign wr_prot   = wb_wr && (I_WB_ADR == OFF_PROT);
    assign wr_defeat = wb_wr && (I_WB_ADR == OFF_DEFEAT);
    assign wr_cfg    = wb_wr && (I_WB_ADR == OFF_CONFIG);
    assign armed     = (defeat == DEF_ARMED);

    assign secure = (opt[1:0] != SEC_OPEN);
    assign key_access_bit = cfg[CFG_KEY_ACCESS_BIT_POS];

    assign status = {27'h0000000, loaded, armed, redirect,
                     prot_active, secure};
    // unmapped offsets read as zero
    assign rd_word = (I_WB_ADR == OFF_PROT)   ? {24'h000000, prot} :
                     (I_WB_ADR == OFF_OPT)    ? {24'h000000, opt}  :
                     (I_WB_ADR == OFF_CONFIG) ? {24'h000000, cfg}  :
                     (I_WB_ADR == OFF_STATUS) ? status :
                     32'h00000000;

    always_comb
    begin
        next_defeat = defeat;
        unique case (defeat)
            DEF_IDLE:
                if (wr_defeat && wb_byte == DEFEAT_FIRST)
                    next_defeat = DEF_FIRST;
            DEF_FIRST:
                if (wb_wr)
                    next_defeat = (wr_defeat && wb_byte == DEFEAT_SECOND) ?
                                  DEF_ARMED : DEF_IDLE;
            DEF_ARMED:
                if (wb_wr && !wr_defeat)
                    next_defeat = DEF_IDLE;
            default:
                next_defeat = DEF_IDLE;
        endcase
    end

    vector_redirect #(
        .FLASH_BASE     (FLASH_BASE)
    ) u_redirect (
        .i_prot         (prot),
        .i_nored        (opt[OPT_NORED_POS]),
        .i_addr         (I_MEM_ADDR),
        .i_fetch        (I_MEM_FETCH),
        .o_last_unprot  (last_unprot),
        .o_prot_active  (prot_active),
        .o_redirect     (redirect),
        .o_in_protected (in_protected),
        .o_addr         (mem_addr_out)
    );

    // memory path gating
    assign tgt_secure = (I_MEM_ADDR >= FLASH_BASE) ||
                        ((I_MEM_ADDR >= RAM_BASE) && (I_MEM_ADDR <= RAM_TOP));
    assign trusted = I_MEM_SECURE_SRC && !I_MEM_DEBUG;
    assign blocked = secure && tgt_secure && !trusted;
    assign key_hit = key_access_bit && I_MEM_WE &&
                     (I_MEM_ADDR >= KEY_BASE) &&
                     (I_MEM_ADDR <= KEY_BASE + 16'(KEY_LEN - 1));
    assign key_wr  = I_MEM_REQ && key_hit && trusted;
    assign arr_req = I_MEM_REQ && !blocked && !key_hit;
    // protected pages refuse the first step of a command
    assign arr_we  = arr_req && I_MEM_WE && !in_protected;

    // order checked, spacing left to software
    key_check u_key (
        .i_clk    (I_MCLK),
        .i_rst_n  (I_RST_N),
        .i_start  (key_access_bit && !key_access_bit_q),
        .i_finish (!key_access_bit && key_access_bit_q),
        .i_wr     (key_wr),
        .i_idx    (3'(I_MEM_ADDR - KEY_BASE)),
        .i_data   (I_MEM_WDATA),
        .i_key    (I_NV_KEY),
        .o_match  (key_match)
    );

    assign unlock = (key_match && opt[OPT_KEY_ENABLE_BIT_POS]) || I_BLANK_OK;

    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h00000000;
            defeat   <= DEF_IDLE;
            cfg      <= CFG_RESET;
            key_access_bit_q <= 1'b0;
        end
        else
        begin
            O_WB_ACK <= wb_req;
            O_WB_DAT <= wb_req ? rd_word : 32'h00000000;
            defeat   <= next_defeat;
            key_access_bit_q <= key_access_bit;
            if (wr_cfg)
                cfg <= wb_byte & (8'h01 << CFG_KEY_ACCESS_BIT_POS);
        end
    end

    // nonvolatile copies land one edge after reset release
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            loaded <= 1'b0;
            prot   <= PROT_RESET;
            opt    <= OPT_RESET;
        end
        else if (!loaded)
        begin
            loaded <= 1'b1;
            prot   <= I_NV_PROT;
            opt    <= I_NV_OPT & OPT_MASK;
        end
        else
        begin
            if (wr_prot && I_WB_DEBUG)
                prot <= wb_byte;
            else if (wr_prot && armed && wb_byte[PROT_DIS_POS])
                prot[PROT_DIS_POS] <= 1'b1;
            if (unlock)
                opt[1:0] <= SEC_OPEN;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_ARRAY_REQ   <= 1'b0;
            O_ARRAY_WE    <= 1'b0;
            O_ARRAY_ADDR  <= 16'h0000;
            O_ARRAY_WDATA <= 8'h00;
            O_MEM_RDATA   <= 8'h00;
            O_MEM_VALID   <= 1'b0;
            O_DEBUG_EN_OK <= 1'b0;
            pend_rd       <= 1'b0;
            pend_zero     <= 1'b0;
        end
        else
        begin
            O_ARRAY_REQ   <= arr_req;
            O_ARRAY_WE    <= arr_we;
            O_ARRAY_ADDR  <= mem_addr_out;
            O_ARRAY_WDATA <= I_MEM_WDATA;
            pend_rd       <= I_MEM_REQ && !I_MEM_WE;
            pend_zero     <= blocked;
            O_MEM_VALID   <= pend_rd;
            O_MEM_RDATA   <= (pend_rd && !pend_zero) ? I_ARRAY_RDATA : 8'h00;
            O_DEBUG_EN_OK <= loaded && !secure;
        end
    end

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);

    a_boundary_ones: assert property (
        prot_active |-> last_unprot[PAGE_BITS-1:0] == PAGE_ONES &&
                        last_unprot[15:PAGE_BITS] == prot[7:1])
        else $error("protect limit not on a page boundary");

    a_prot_loaded: assert property (
        !loaded ##1 loaded |-> prot == $past(I_NV_PROT))
        else $error("protect copy not taken from flash");

    a_app_write_ignored: assert property (
        loaded && wr_prot && !I_WB_DEBUG && !armed |=> $stable(prot))
        else $error("application write changed protect copy");

    a_limit_shape: assert property (
        last_unprot == {prot[7:1], 9'h1FF})
        else $error("last unprotected address malformed");

    a_disable_off: assert property (
        prot[PROT_DIS_POS] |-> !prot_active && !in_protected)
        else $error("protection active with disable bit set");

    a_defeat_needed: assert property (
        loaded && $rose(prot[PROT_DIS_POS]) |->
            $past(I_WB_DEBUG) || $past(defeat) == DEF_ARMED)
        else $error("protection dropped without defeat sequence");

    a_redirect_cond: assert property (
        redirect |-> !opt[OPT_NORED_POS] && prot_active &&
                     last_unprot != FLASH_TOP)
        else $error("redirect outside its conditions");

    a_whole_no_redirect: assert property (
        prot_active && last_unprot < FLASH_BASE |-> !redirect)
        else $error("redirect while whole array protected");

    a_reset_vector: assert property (
        I_MEM_REQ && I_MEM_ADDR > VEC_HI |=>
            O_ARRAY_ADDR == $past(I_MEM_ADDR))
        else $error("reset vector address was moved");

    a_vector_moved: assert property (
        redirect && I_MEM_FETCH && I_MEM_ADDR >= VEC_LO &&
        I_MEM_ADDR <= VEC_HI |=>
            O_ARRAY_ADDR[8:0] == $past(I_MEM_ADDR[8:0]) &&
            O_ARRAY_ADDR[15:9] == $past(last_unprot[15:9]))
        else $error("redirected vector address wrong");

    a_blocked_zero: assert property (
        I_MEM_REQ && !I_MEM_WE && blocked |=> !O_ARRAY_REQ ##1
            O_MEM_VALID && O_MEM_RDATA == 8'h00)
        else $error("blocked read leaked data");

    a_trusted_access: assert property (
        I_MEM_REQ && trusted && !key_hit |=> O_ARRAY_REQ)
        else $error("secure code access was blocked");

    a_debug_secure: assert property (
        secure |=> !O_DEBUG_EN_OK)
        else $error("debug allowed while secure");

    a_key_enable_bit_off: assert property (
        loaded && !opt[OPT_KEY_ENABLE_BIT_POS] && !I_BLANK_OK && secure |=> secure)
        else $error("security lifted with key disabled");

    a_key_no_write: assert property (
        I_MEM_REQ && key_hit |=> !O_ARRAY_WE && !O_ARRAY_REQ)
        else $error("key write reached the array");

    a_blank_unsecure: assert property (
        loaded && I_BLANK_OK |=> !secure [*3])
        else $error("blank check did not unsecure");

    c_defeat_armed: cover property (
        defeat == DEF_FIRST ##1 defeat == DEF_ARMED);
    c_key_unlock: cover property (key_match && opt[OPT_KEY_ENABLE_BIT_POS]);
    c_redirect_fetch: cover property (redirect && I_MEM_FETCH && I_MEM_REQ);
    c_blocked_read: cover property (I_MEM_REQ && blocked && !I_MEM_WE);
endmodule
`default_nettype wire

/* src/flash_guard_pkg.sv */
package flash_guard_pkg;

    // register word offsets on the bus
    localparam logic [7:0]  OFF_PROT     = 8'h00;
    localparam logic [7:0]  OFF_DEFEAT   = 8'h04;
    localparam logic [7:0]  OFF_OPT      = 8'h08;
    localparam logic [7:0]  OFF_CONFIG   = 8'h0C;
    localparam logic [7:0]  OFF_STATUS   = 8'h10;

    // nonvolatile byte locations in the flash map
    localparam logic [15:0] NV_PROT_ADDR = 16'hFFBD;
    localparam logic [15:0] NV_OPT_ADDR  = 16'hFFBF;

    localparam int          PAGE_BITS    = 9;
    localparam logic [8:0]  PAGE_ONES    = 9'h1FF;
    localparam logic [15:0] FLASH_TOP    = 16'hFFFF;
    localparam logic [15:0] VEC_LO       = 16'hFFC0;
    localparam logic [15:0] VEC_HI       = 16'hFFFD;

    localparam logic [7:0]  DEFEAT_FIRST = 8'h55;
    localparam logic [7:0]  DEFEAT_SECOND = 8'hAA;

    localparam int          PROT_DIS_POS = 0;
    localparam int          OPT_KEY_ENABLE_BIT_POS = 7;
    localparam int          OPT_NORED_POS = 6;
    localparam logic [7:0]  OPT_MASK     = 8'hC3;
    localparam logic [1:0]  SEC_OPEN     = 2'b10;
    localparam int          CFG_KEY_ACCESS_BIT_POS = 5;

    localparam int          ST_SECURE    = 0;
    localparam int          ST_PROT      = 1;
    localparam int          ST_REDIRECT  = 2;
    localparam int          ST_ARMED     = 3;
    localparam int          ST_LOADED    = 4;

    // prot and opt values held until the nonvolatile copy lands; config held until written
    localparam logic [7:0]  PROT_RESET   = 8'hFF;
    localparam logic [7:0]  OPT_RESET    = 8'h03;
    localparam logic [7:0]  CFG_RESET    = 8'h00;

    localparam int          KEY_LEN      = 8;

    typedef enum logic [2:0] {
        DEF_IDLE  = 3'b001,
        DEF_FIRST = 3'b010,
        DEF_ARMED = 3'b100
    } defeat_state_t;

endpackage

/* src/vector_redirect.sv */
`timescale 1ns/1ps
`default_nettype none
module vector_redirect
    import flash_guard_pkg::*;
#(
    parameter logic [15:0] FLASH_BASE = 16'hC000
)(
    input  wire logic [7:0]  i_prot,
    input  wire logic        i_nored,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_fetch,
    output logic [15:0]      o_last_unprot,
    output logic             o_prot_active,
    output logic             o_redirect,
    output logic             o_in_protected,
    output logic [15:0]      o_addr
);
    wire logic partial;
    wire logic in_vec;

    assign o_last_unprot  = {i_prot[7:1], PAGE_ONES};
    assign o_prot_active  = ~i_prot[PROT_DIS_POS];
    // region up to top of flash
    assign o_in_protected = o_prot_active && (i_addr > o_last_unprot);
    assign partial = (o_last_unprot != FLASH_TOP) &&
                     (o_last_unprot >= FLASH_BASE);
    assign o_redirect = ~i_nored && o_prot_active && partial;
    assign in_vec = i_fetch && (i_addr >= VEC_LO) && (i_addr <= VEC_HI);
    assign o_addr = (o_redirect && in_vec) ?
                    {o_last_unprot[15:PAGE_BITS], i_addr[PAGE_BITS-1:0]} :
                    i_addr;
endmodule
`default_nettype wire

/* src/key_check.sv */
`timescale 1ns/1ps
`default_nettype none
module key_check
    import flash_guard_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_start,
    input  wire logic        i_finish,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_idx,
    input  wire logic [7:0]  i_data,
    input  wire logic [63:0] i_key,
    output logic             o_match
);
    logic [3:0] count;
    logic       bad;
    wire logic  wrong;

    // out of order or extra bytes spoil the try
    assign wrong = count[3] || (i_idx != count[2:0]) ||
                   (i_data != i_key[8*count[2:0] +: 8]);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count   <= 4'h0;
            bad     <= 1'b0;
            o_match <= 1'b0;
        end
        else
        begin
            o_match <= 1'b0;
            if (i_start)
            begin
                count <= 4'h0;
                bad   <= 1'b0;
            end
            else if (i_wr)
            begin
                count <= count + 4'h1;
                bad   <= bad | wrong;
            end
            if (i_finish)
                o_match <= !bad && (count == 4'(KEY_LEN));
        end
    end
endmodule
`default_nettype wire

/* verification/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    output logic [7:0]       o_rdata
);
    wire [7:0] pattern = i_addr[15:8] ^ i_addr[7:0];

    // off-request data is inverted so a stale sample never matches
    assign o_rdata = i_req ? pattern : ~pattern;
endmodule
`default_nettype wire

/* verification/flash_guard_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_guard_tb;
    import flash_guard_pkg::*;

    localparam logic [15:0] KEY_AT = 16'hFFB0;

    logic        mclk, rst_n, cyc, stb, we, dbg, blank;
    logic        mreq, mwe, mfetch, msec, mdbg;
    logic        ack, areq, awe, mvalid, dbg_ok, s_req, s_we, s_val;
    logic [7:0]  adr, nv_prot, nv_opt, mwdata, ardata, mrdata, got;
    logic [7:0]  awdata, s_wdata;
    logic [15:0] maddr, aaddr, s_addr;
    logic [31:0] wdat, rdat;
    logic [63:0] nv_key;
    int          miscompares, checks_done, cycles;

    flash_guard #(.KEY_BASE(KEY_AT)) i_dut (
        .I_MCLK           (mclk),
        .I_RST_N          (rst_n),
        .I_WB_CYC         (cyc),
        .I_WB_STB         (stb),
        .I_WB_WE          (we),
        .I_WB_ADR         (adr),
        .I_WB_SEL         (4'h1),
        .I_WB_DAT         (wdat),
        .I_WB_DEBUG       (dbg),
        .O_WB_DAT         (rdat),
        .O_WB_ACK         (ack),
        .I_NV_PROT        (nv_prot),
        .I_NV_OPT         (nv_opt),
        .I_NV_KEY         (nv_key),
        .I_BLANK_OK       (blank),
        .I_MEM_REQ        (mreq),
        .I_MEM_WE         (mwe),
        .I_MEM_FETCH      (mfetch),
        .I_MEM_ADDR       (maddr),
        .I_MEM_WDATA      (mwdata),
        .I_MEM_SECURE_SRC (msec),
        .I_MEM_DEBUG      (mdbg),
        .I_ARRAY_RDATA    (ardata),
        .O_ARRAY_REQ      (areq),
        .O_ARRAY_WE       (awe),
        .O_ARRAY_ADDR     (aaddr),
        .O_ARRAY_WDATA    (awdata),
        .O_MEM_RDATA      (mrdata),
        .O_MEM_VALID      (mvalid),
        .O_DEBUG_EN_OK    (dbg_ok)
    );

    flash_array_model i_array (
        .i_req   (areq),
        .i_addr  (aaddr),
        .o_rdata (ardata)
    );

    always #5 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e)
        begin
            miscompares++;
            $display("unexpected at %0t seen %h expected %h", $time, a, e);
        end
    endtask

    // held until the ack edge, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic db);
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        dbg  <= db;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 1'b0);
        check(rdat, {24'h0, e});
    endtask

    // two cycles between requests, so never on adjacent cycles
    task automatic mem(input logic w, input logic f, input logic [15:0] a,
                       input logic [7:0] d, input logic s, input logic db);
        @(posedge mclk);
        mreq   <= 1'b1;
        mwe    <= w;
        mfetch <= f;
        maddr  <= a;
        mwdata <= d;
        msec   <= s;
        mdbg   <= db;
        @(posedge mclk);
        mreq <= 1'b0;
        #1;
        s_req  = areq;
        s_we   = awe;
        s_addr = aaddr;
        s_wdata = awdata;
        @(posedge mclk);
        #1;
        got = mrdata;
        s_val = mvalid;
    endtask

    // db high sends the key from the debug side, which must not count
    task automatic key(input logic [63:0] k, input logic db);
        wb(1'b1, OFF_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < KEY_LEN; i++)
        begin
            mem(1'b1, 1'b0, KEY_AT + 16'(i), k[8*i +: 8], 1'b1, db);
            check(s_req, 1'b0);
        end
        wb(1'b1, OFF_CONFIG, 8'h00, 1'b0);
        repeat (3) @(posedge mclk);
    endtask

    task automatic rst(input logic [7:0] p, input logic [7:0] o);
        @(posedge mclk);
        rst_n   <= 1'b0;
        nv_prot <= p;
        nv_opt  <= o;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    initial
    begin
        {mclk, rst_n, cyc, stb, we, dbg, blank} = '0;
        {mreq, mwe, mfetch, msec, mdbg, adr, wdat, mwdata, maddr} = '0;
        {miscompares, checks_done, cycles} = '0;
        nv_prot = 8'hFF;
        nv_opt = 8'h03;
        nv_key = 64'h0123456789ABCDEF;
        for (int i = 0; i < 4; i++)
        begin
            rst(8'hF8, 8'h40 | 8'(i));
            rd(OFF_STATUS, 8'h12 | 8'(i != 2));
            check(dbg_ok, 32'(i == 2));
        end
        $display("test security codes done");
        rst(8'hF8, 8'h83);
        rd(OFF_PROT, 8'hF8);
        rd(OFF_OPT, 8'h83);
        rd(OFF_CONFIG, 8'h00);
        rd(OFF_STATUS, 8'h17);
        rd(8'h14, 8'h00);
        wb(1'b1, OFF_PROT, 8'h01, 1'b0);
        wb(1'b1, OFF_OPT, 8'h00, 1'b0);
        rd(OFF_PROT, 8'hF8);
        rd(OFF_OPT, 8'h83);
        $display("test registers done");
        mem(1'b0, 1'b0, 16'hC100, 8'h00, 1'b0, 1'b0);
        check({s_val, s_req, got}, 10'h200);
        mem(1'b0, 1'b0, 16'h0100, 8'h00, 1'b1, 1'b1);
        check({s_val, s_req, got}, 10'h200);
        mem(1'b1, 1'b0, 16'h0100, 8'h5A, 1'b0, 1'b0);
        check({s_val, s_req}, 2'b00);
        mem(1'b0, 1'b0, 16'hC100, 8'h00, 1'b1, 1'b0);
        check({s_val, s_req, got}, 10'h3C1);
        $display("test security blocking done");
        key(nv_key, 1'b1);
        rd(OFF_STATUS, 8'h17);
        key(64'h0123456789ABCDEE, 1'b0);
        rd(OFF_STATUS, 8'h17);
        key(nv_key, 1'b0);
        rd(OFF_STATUS, 8'h16);
        check(dbg_ok, 1'b1);
        mem(1'b0, 1'b0, 16'hC100, 8'h00, 1'b0, 1'b0);
        check(got, 8'hC1);
        $display("test key unlock done");
        mem(1'b0, 1'b1, 16'hFFE0, 8'h00, 1'b1, 1'b0);
        check(s_addr, 16'hF9E0);
        mem(1'b0, 1'b1, 16'hFFFE, 8'h00, 1'b1, 1'b0);
        check(s_addr, 16'hFFFE);
        mem(1'b1, 1'b0, 16'hFA00, 8'h11, 1'b1, 1'b0);
        check({s_req, s_we}, 2'b10);
        mem(1'b1, 1'b0, 16'hF9FF, 8'h11, 1'b1, 1'b0);
        check({s_req, s_we, s_addr}, 18'h3F9FF);
        check(s_wdata, 8'h11);
        $display("test redirect done");
        // broken sequence first, then the real one
        wb(1'b1, OFF_DEFEAT, DEFEAT_FIRST, 1'b0);
        wb(1'b1, OFF_CONFIG, 8'h00, 1'b0);
        wb(1'b1, OFF_DEFEAT, DEFEAT_SECOND, 1'b0);
        rd(OFF_STATUS, 8'h16);
        wb(1'b1, OFF_DEFEAT, DEFEAT_FIRST, 1'b0);
        wb(1'b1, OFF_DEFEAT, DEFEAT_SECOND, 1'b0);
        rd(OFF_STATUS, 8'h1E);
        wb(1'b1, OFF_PROT, 8'h01, 1'b0);
        rd(OFF_PROT, 8'hF9);
        rd(OFF_STATUS, 8'h10);
        mem(1'b0, 1'b1, 16'hFFE0, 8'h00, 1'b1, 1'b0);
        check(s_addr, 16'hFFE0);
        wb(1'b1, OFF_PROT, 8'hFC, 1'b1);
        rd(OFF_PROT, 8'hFC);
        mem(1'b0, 1'b1, 16'hFFC2, 8'h00, 1'b1, 1'b0);
        check(s_addr, 16'hFDC2);
        // whole array protected: no redirection
        wb(1'b1, OFF_PROT, 8'h7E, 1'b1);
        rd(OFF_STATUS, 8'h12);
        mem(1'b0, 1'b1, 16'hFFE0, 8'h00, 1'b1, 1'b0);
        check(s_addr, 16'hFFE0);
        $display("test defeat done");
        rst(8'hFF, 8'h03);
        key(nv_key, 1'b0);
        rd(OFF_STATUS, 8'h11);
        @(posedge mclk);
        blank <= 1'b1;
        @(posedge mclk);
        blank <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(OFF_STATUS, 8'h10);
        $display("test blank check done");
        wrap_up();
    end
endmodule
`default_nettype wire
